// ==== verilog/bridge_window_ext_regs.sv ====
`timescale 1ns/10ps
module bridge_window_ext_regs (
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_CFG_WR,
   input  wire logic        I_CFG_RD,
   input  wire logic [7:0]  I_CFG_ADDR,
   input  wire logic [3:0]  I_CFG_BE,
   input  wire logic [31:0] I_CFG_WDATA,
   output logic      [31:0] O_CFG_RDATA,
   output logic             O_CFG_RVALID,
   input  wire logic [11:0] I_PF_BASE_LO,
   input  wire logic [11:0] I_PF_LIMIT_LO,
   input  wire logic [3:0]  I_IO_BASE_LO,
   input  wire logic [3:0]  I_IO_LIMIT_LO,
   input  wire logic [63:0] I_MEM_ADDR,
   input  wire logic [31:0] I_IO_ADDR,
   output logic             O_PF_HIT,
   output logic             O_IO_HIT,
   input  wire logic        I_SEC_PARITY_ERR,
   input  wire logic        I_SECONDARY_SYSTEM_ERROR_N,
   output logic             O_SEC_PARITY_REPORT,
   output logic             O_PRI_SYSTEM_ERROR,
   output logic             O_PARITY_RESP_EN,
   output logic             O_SERR_FWD_EN
);
   // ==========================================================
   // Byte-enable merge
   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   // ==========================================================
   // Offset match, shared by every write strobe
   function automatic logic cfg_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
      return addr == ofs;
   endfunction : cfg_hit

   logic [31:0] pf_base_high_reg;
   logic [31:0] pf_limit_high_reg;
   logic [15:0] io_base_high_reg;
   logic [15:0] io_limit_high_reg;
   logic [7:0]  int_line_reg;
   logic        perr_resp_reg;
   logic        serr_fwd_reg;
   logic [31:0] io_dword;
   logic [31:0] int_dword;
   logic [31:0] rdata_next;
   logic [31:0] int_merged;
   logic [31:0] io_merged;
   logic        wr_pf_base;
   logic        wr_pf_limit;
   logic        wr_io_high;
   logic        wr_int_bctl;

   assign io_dword  = {io_limit_high_reg, io_base_high_reg};
   assign int_dword = {14'h0, serr_fwd_reg, perr_resp_reg,
                       bridge_ext_pkg::INT_PIN_VALUE, int_line_reg};
   assign int_merged = merge_be(int_dword, I_CFG_WDATA, I_CFG_BE);
   assign io_merged  = merge_be(io_dword, I_CFG_WDATA, I_CFG_BE);
   assign wr_pf_base  = I_CFG_WR && cfg_hit(I_CFG_ADDR, bridge_ext_pkg::OFS_PF_BASE_HIGH);
   assign wr_pf_limit = I_CFG_WR && cfg_hit(I_CFG_ADDR, bridge_ext_pkg::OFS_PF_LIMIT_HIGH);
   assign wr_io_high  = I_CFG_WR && cfg_hit(I_CFG_ADDR, bridge_ext_pkg::OFS_IO_HIGH);
   assign wr_int_bctl = I_CFG_WR && cfg_hit(I_CFG_ADDR, bridge_ext_pkg::OFS_INT_BCTL);

   // ==========================================================
   // Prefetch window base, upper half
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pf_base_high_reg <= bridge_ext_pkg::PF_HIGH_RESET;
      end else if (wr_pf_base) begin
         pf_base_high_reg <= merge_be(pf_base_high_reg, I_CFG_WDATA, I_CFG_BE);
      end
   end

   // ==========================================================
   // Prefetch window limit, upper half
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         pf_limit_high_reg <= bridge_ext_pkg::PF_HIGH_RESET;
      end else if (wr_pf_limit) begin
         pf_limit_high_reg <= merge_be(pf_limit_high_reg, I_CFG_WDATA, I_CFG_BE);
      end
   end

   // ==========================================================
   // I/O window upper halves
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         io_base_high_reg  <= bridge_ext_pkg::IO_HIGH_RESET;
         io_limit_high_reg <= bridge_ext_pkg::IO_HIGH_RESET;
      end else if (wr_io_high) begin
         io_base_high_reg  <= io_merged[bridge_ext_pkg::IO_BASE_LSB +: 16];
         io_limit_high_reg <= io_merged[bridge_ext_pkg::IO_LIMIT_LSB +: 16];
      end
   end

   // ==========================================================
   // Interrupt line byte
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         int_line_reg <= bridge_ext_pkg::INT_LINE_RESET;
      end else if (wr_int_bctl) begin
         int_line_reg <= int_merged[bridge_ext_pkg::INT_LINE_LSB +: 8];
      end
   end

   // ==========================================================
   // Bridge control bits
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         perr_resp_reg <= bridge_ext_pkg::BCTL_RESET;
         serr_fwd_reg  <= bridge_ext_pkg::BCTL_RESET;
      end else if (wr_int_bctl) begin
         perr_resp_reg <= int_merged[bridge_ext_pkg::BCTL_PERR_BIT];
         serr_fwd_reg  <= int_merged[bridge_ext_pkg::BCTL_SERR_BIT];
      end
   end

   // ==========================================================
   // Read mux, unmapped offsets read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (I_CFG_ADDR)
         bridge_ext_pkg::OFS_PF_BASE_HIGH:  rdata_next = pf_base_high_reg;
         bridge_ext_pkg::OFS_PF_LIMIT_HIGH: rdata_next = pf_limit_high_reg;
         bridge_ext_pkg::OFS_IO_HIGH:       rdata_next = io_dword;
         bridge_ext_pkg::OFS_CAP_PTR:       rdata_next = {24'h000000,
                                                bridge_ext_pkg::CAP_PTR_VALUE};
         bridge_ext_pkg::OFS_INT_BCTL:      rdata_next = int_dword;
         default:                           rdata_next = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // Read answer strobe, one cycle after the read
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CFG_RVALID <= 1'b0;
      end else begin
         O_CFG_RVALID <= I_CFG_RD;
      end
   end

   // ==========================================================
   // Read data, held until the next read
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_CFG_RDATA <= 32'h0000_0000;
      end else if (I_CFG_RD) begin
         O_CFG_RDATA <= rdata_next;
      end
   end

   // ==========================================================
   // Secondary parity error report, gated by the response bit
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_SEC_PARITY_REPORT <= 1'b0;
         O_PARITY_RESP_EN    <= 1'b0;
      end else begin
         O_SEC_PARITY_REPORT <= perr_resp_reg && I_SEC_PARITY_ERR;
         O_PARITY_RESP_EN    <= perr_resp_reg;
      end
   end

   // ==========================================================
   // Secondary system error forwarding, gated by the enable bit
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PRI_SYSTEM_ERROR <= 1'b0;
         O_SERR_FWD_EN      <= 1'b0;
      end else begin
         O_PRI_SYSTEM_ERROR <= serr_fwd_reg && !I_SECONDARY_SYSTEM_ERROR_N;
         O_SERR_FWD_EN      <= serr_fwd_reg;
      end
   end

   // ==========================================================
   // Prefetch window decoder
   window_hit #(.W(64)) u_pf_hit (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_addr  (I_MEM_ADDR),
      .i_base  ({pf_base_high_reg, I_PF_BASE_LO,
                 {bridge_ext_pkg::PF_LOW_ZERO_W{1'b0}}}),
      .i_limit ({pf_limit_high_reg, I_PF_LIMIT_LO,
                 {bridge_ext_pkg::PF_LOW_ZERO_W{1'b1}}}),
      .o_hit   (O_PF_HIT)
   );

   // ==========================================================
   // I/O window decoder
   window_hit #(.W(32)) u_io_hit (
      .i_clk   (I_CLK),
      .i_rst   (I_RST),
      .i_addr  (I_IO_ADDR),
      .i_base  ({io_base_high_reg, I_IO_BASE_LO,
                 {bridge_ext_pkg::IO_LOW_ZERO_W{1'b0}}}),
      .i_limit ({io_limit_high_reg, I_IO_LIMIT_LO,
                 {bridge_ext_pkg::IO_LOW_ZERO_W{1'b1}}}),
      .o_hit   (O_IO_HIT)
   );
endmodule : bridge_window_ext_regs

// ==== verilog/bridge_ext_pkg.sv ====
package bridge_ext_pkg;
   // ==========================================================
   // Register offsets (byte addresses of configuration dwords)
   localparam logic [7:0] OFS_PF_BASE_HIGH  = 8'h28;
   localparam logic [7:0] OFS_PF_LIMIT_HIGH = 8'h2c;
   localparam logic [7:0] OFS_IO_HIGH       = 8'h30;
   localparam logic [7:0] OFS_CAP_PTR       = 8'h34;
   localparam logic [7:0] OFS_INT_BCTL      = 8'h3c;
   // ==========================================================
   // Field positions
   localparam int IO_BASE_LSB    = 0;
   localparam int IO_LIMIT_LSB   = 16;
   localparam int INT_LINE_LSB   = 0;
   localparam int INT_PIN_LSB    = 8;
   localparam int BCTL_PERR_BIT  = 16;
   localparam int BCTL_SERR_BIT  = 17;
   localparam int PF_LOW_ZERO_W  = 20;
   localparam int IO_LOW_ZERO_W  = 12;
   // ==========================================================
   // Reset and fixed values
   localparam logic [31:0] PF_HIGH_RESET  = 32'h0000_0000;
   localparam logic [15:0] IO_HIGH_RESET  = 16'h0000;
   localparam logic [7:0]  CAP_PTR_VALUE  = 8'hdc;
   localparam logic [7:0]  INT_LINE_RESET = 8'h00;
   localparam logic [7:0]  INT_PIN_VALUE  = 8'h00;
   localparam logic        BCTL_RESET     = 1'b0;
endpackage : bridge_ext_pkg

// ==== verilog/window_hit.sv ====
`timescale 1ns/10ps
module window_hit #(
   parameter int W = 64
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_addr,
   input  wire logic [W-1:0] i_base,
   input  wire logic [W-1:0] i_limit,
   output logic              o_hit
);
   // ==========================================================
   // Inclusive range compare
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_hit <= 1'b0;
      end else begin
         o_hit <= (i_addr >= i_base) && (i_addr <= i_limit);
      end
   end
endmodule : window_hit

// ==== tb/sec_bus_agent.sv ====
`timescale 1ns/10ps
// ====================
// Secondary bus agent: random parity and system error events
module sec_bus_agent (
   input  wire logic i_clk,
   output logic      o_perr,
   output logic      o_serr_n
);
   initial begin
      o_perr   = 1'b0;
      o_serr_n = 1'b1;
      forever begin
         @(posedge i_clk);
         #1;
         o_perr   = ($urandom() % 2) == 1;
         o_serr_n = ($urandom() % 3) != 0;
      end
   end
endmodule : sec_bus_agent

// ==== tb/bridge_window_ext_regs_sva.sv ====
`timescale 1ns/10ps
// ====================
// Checker
module bwe_sva (
   input wire logic        I_CLK,
   input wire logic        I_RST,
   input wire logic        I_CFG_RD,
   input wire logic        I_CFG_WR,
   input wire logic [7:0]  I_CFG_ADDR,
   input wire logic [3:0]  I_CFG_BE,
   input wire logic [31:0] I_CFG_WDATA,
   input wire logic [31:0] O_CFG_RDATA,
   input wire logic        O_CFG_RVALID,
   input wire logic        I_SEC_PARITY_ERR,
   input wire logic        I_SECONDARY_SYSTEM_ERROR_N,
   input wire logic        O_SEC_PARITY_REPORT,
   input wire logic        O_PRI_SYSTEM_ERROR,
   input wire logic        O_PARITY_RESP_EN,
   input wire logic        O_SERR_FWD_EN
);
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   sequence s_ctl_wr;
      I_CFG_WR && I_CFG_ADDR == 8'h3c && I_CFG_BE[2];
   endsequence
   sequence s_perr_seen;
      I_SEC_PARITY_ERR ##1 O_PARITY_RESP_EN;
   endsequence
   sequence s_serr_seen;
      !I_SECONDARY_SYSTEM_ERROR_N ##1 O_SERR_FWD_EN;
   endsequence
   a_read_answer: assert property (I_CFG_RD |=> O_CFG_RVALID) else $error("no read answer");
   a_cap_ptr: assert property (I_CFG_RD && I_CFG_ADDR == 8'h34 |=>
      O_CFG_RDATA[7:0] == 8'hdc) else $error("capability pointer wrong");
   a_int_pin_ro: assert property (I_CFG_RD && I_CFG_ADDR == 8'h3c |=>
      O_CFG_RDATA[15:8] == 8'h00) else $error("interrupt pin not zero");
   a_ctl_write: assert property (s_ctl_wr |=> ##1
      (O_PARITY_RESP_EN == $past(I_CFG_WDATA[16], 2) &&
       O_SERR_FWD_EN == $past(I_CFG_WDATA[17], 2))) else $error("control bits not written");
   a_parity_report: assert property (s_perr_seen |->
      O_SEC_PARITY_REPORT) else $error("parity error not reported");
   a_parity_ignore: assert property (!O_PARITY_RESP_EN |->
      !O_SEC_PARITY_REPORT) else $error("parity error not ignored");
   a_serr_forward: assert property (s_serr_seen |->
      O_PRI_SYSTEM_ERROR) else $error("system error not forwarded");
   a_serr_block: assert property (!O_SERR_FWD_EN |->
      !O_PRI_SYSTEM_ERROR) else $error("system error not blocked");
endmodule : bwe_sva

// ==== tb/bridge_window_ext_regs_bench.sv ====
`timescale 1ns/10ps
// ====================
// Bench
module bridge_window_ext_regs_bench;
   logic        I_CLK = 0, I_RST = 1, I_CFG_WR = 0, I_CFG_RD = 0;
   logic [7:0]  I_CFG_ADDR = 8'h00;
   logic [3:0]  I_CFG_BE = 4'h0, I_IO_BASE_LO = 4'h0, I_IO_LIMIT_LO = 4'h0;
   logic [11:0] I_PF_BASE_LO = 12'h000, I_PF_LIMIT_LO = 12'h000;
   logic [31:0] I_CFG_WDATA = 32'h0, I_IO_ADDR = 32'h0, O_CFG_RDATA, d;
   logic [63:0] I_MEM_ADDR = 64'h0;
   logic        O_CFG_RVALID, O_PF_HIT, O_IO_HIT, I_SEC_PARITY_ERR, I_SECONDARY_SYSTEM_ERROR_N;
   logic        O_SEC_PARITY_REPORT, O_PRI_SYSTEM_ERROR, O_PARITY_RESP_EN, O_SERR_FWD_EN;
   logic [31:0] qr[$];
   logic [1:0]  qh[$];
   int          n_fail = 0, compares = 0;
   bridge_window_ext_regs dut_u (
      .I_CLK                      (I_CLK),
      .I_RST                      (I_RST),
      .I_CFG_WR                   (I_CFG_WR),
      .I_CFG_RD                   (I_CFG_RD),
      .I_CFG_ADDR                 (I_CFG_ADDR),
      .I_CFG_BE                   (I_CFG_BE),
      .I_CFG_WDATA                (I_CFG_WDATA),
      .O_CFG_RDATA                (O_CFG_RDATA),
      .O_CFG_RVALID               (O_CFG_RVALID),
      .I_PF_BASE_LO               (I_PF_BASE_LO),
      .I_PF_LIMIT_LO              (I_PF_LIMIT_LO),
      .I_IO_BASE_LO               (I_IO_BASE_LO),
      .I_IO_LIMIT_LO              (I_IO_LIMIT_LO),
      .I_MEM_ADDR                 (I_MEM_ADDR),
      .I_IO_ADDR                  (I_IO_ADDR),
      .O_PF_HIT                   (O_PF_HIT),
      .O_IO_HIT                   (O_IO_HIT),
      .I_SEC_PARITY_ERR           (I_SEC_PARITY_ERR),
      .I_SECONDARY_SYSTEM_ERROR_N (I_SECONDARY_SYSTEM_ERROR_N),
      .O_SEC_PARITY_REPORT        (O_SEC_PARITY_REPORT),
      .O_PRI_SYSTEM_ERROR         (O_PRI_SYSTEM_ERROR),
      .O_PARITY_RESP_EN           (O_PARITY_RESP_EN),
      .O_SERR_FWD_EN              (O_SERR_FWD_EN)
   );
   sec_bus_agent agent_u (.i_clk(I_CLK), .o_perr(I_SEC_PARITY_ERR),
      .o_serr_n(I_SECONDARY_SYSTEM_ERROR_N));
   initial begin
      forever #2.5 I_CLK = ~I_CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic step;
      @(posedge I_CLK);
      #1;
   endtask : step
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
      I_CFG_WR = 1;
      I_CFG_RD = 0;
      I_CFG_ADDR = a;
      I_CFG_BE = be;
      I_CFG_WDATA = v;
      step();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      I_CFG_RD = 1;
      I_CFG_WR = 0;
      I_CFG_ADDR = a;
      step();
      qr.push_back(e);
   endtask : rd
   task automatic dec(input logic [63:0] m, input logic [31:0] io, input logic [1:0] e);
      I_MEM_ADDR = m;
      I_IO_ADDR = io;
      step();
      qh.push_back(e);
   endtask : dec
   task automatic idle(input int n);
      I_CFG_WR = 0;
      I_CFG_RD = 0;
      repeat (n) step();
   endtask : idle
   task automatic test_done;
      chk(32'(qr.size() + qh.size()), 32'h0);
      if (n_fail == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   // ====================
   // Result monitor
   always @(negedge I_CLK) begin
      if (O_CFG_RVALID === 1'b1 && qr.size() > 0) chk(O_CFG_RDATA, qr.pop_front());
      if (qh.size() > 0) chk({30'h0, O_PF_HIT, O_IO_HIT}, {30'h0, qh.pop_front()});
   end
   initial begin
      #100000;
      n_fail++;
      test_done();
   end
   // ====================
   // Main sequence
   initial begin
      void'($urandom(83));
      repeat (16) @(posedge I_CLK);
      #1 I_RST = 0;
      rd(8'h28, 32'h0);
      rd(8'h30, 32'h0);
      rd(8'h3c, 32'h0);
      rd(8'h38, 32'h0);
      for (int i = 0; i < 3; i++) begin
         d = $urandom();
         wr(8'h28 + 8'(4 * i), 4'hf, d);
         rd(8'h28 + 8'(4 * i), d);
      end
      wr(8'h30, 4'h3, 32'hffff_aaaa);
      rd(8'h30, {d[31:16], 16'haaaa});
      wr(8'h34, 4'hf, 32'h0);
      rd(8'h34, 32'h0000_00dc);
      wr(8'h3c, 4'hf, 32'hffff_ffff);
      rd(8'h3c, 32'h0003_00ff);
      wr(8'h28, 4'hf, 32'h1);
      wr(8'h2c, 4'hf, 32'h1);
      wr(8'h30, 4'hf, 32'h0002_0002);
      idle(20);
      I_PF_BASE_LO = 12'h100;
      I_PF_LIMIT_LO = 12'h1ff;
      I_IO_BASE_LO = 4'h1;
      I_IO_LIMIT_LO = 4'h2;
      dec(64'h1_1000_0000, 32'h0002_1000, 2'b11);
      dec(64'h1_0fff_ffff, 32'h0002_0fff, 2'b00);
      dec(64'h1_1fff_ffff, 32'h0002_2fff, 2'b11);
      dec(64'h2_1000_0000, 32'h0002_3000, 2'b00);
      wr(8'h3c, 4'h4, 32'h0);
      rd(8'h3c, 32'h0000_00ff);
      idle(20);
      test_done();
   end
endmodule : bridge_window_ext_regs_bench
bind bridge_window_ext_regs bwe_sva chk_u (
   .I_CLK                      (I_CLK),
   .I_RST                      (I_RST),
   .I_CFG_RD                   (I_CFG_RD),
   .I_CFG_WR                   (I_CFG_WR),
   .I_CFG_ADDR                 (I_CFG_ADDR),
   .I_CFG_BE                   (I_CFG_BE),
   .I_CFG_WDATA                (I_CFG_WDATA),
   .O_CFG_RDATA                (O_CFG_RDATA),
   .O_CFG_RVALID               (O_CFG_RVALID),
   .I_SEC_PARITY_ERR           (I_SEC_PARITY_ERR),
   .I_SECONDARY_SYSTEM_ERROR_N (I_SECONDARY_SYSTEM_ERROR_N),
   .O_SEC_PARITY_REPORT        (O_SEC_PARITY_REPORT),
   .O_PRI_SYSTEM_ERROR         (O_PRI_SYSTEM_ERROR),
   .O_PARITY_RESP_EN           (O_PARITY_RESP_EN),
   .O_SERR_FWD_EN              (O_SERR_FWD_EN)
);
